// ===== src/uart_chan.sv
`timescale 1ns/1ps
`include "uart_chan_map.svh"

module uart_chan
  import uart_chan_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_a,
  input  wire logic        ring_indicator_n_a,
  output logic             serial_out_a,
  output logic             multi_function_out_a,
  output logic             receive_ready_n,
  output logic             transmit_ready_n_a,
  output logic             request_to_send_n_a,
  output logic             terminal_ready_n_a,
  output logic             modem_irq
);

  function automatic fifo_state_s fifo_next(input fifo_state_s s,
                                            input logic push,
                                            input logic pop);
    fifo_state_s n;
    n = s;
    if (push)
    begin
      n.wr_ptr = s.wr_ptr + 4'h1;
    end
    if (pop)
    begin
      n.rd_ptr = s.rd_ptr + 4'h1;
    end
    if (push && !pop)
    begin
      n.count = s.count + 5'h01;
    end
    else if (pop && !push)
    begin
      n.count = s.count - 5'h01;
    end
    return n;
  endfunction

  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'b00:   trig_level = `TRIG_0;
      2'b01:   trig_level = `TRIG_1;
      2'b10:   trig_level = `TRIG_2;
      default: trig_level = `TRIG_3;
    endcase
  endfunction

  logic [7:0]  int_en_q;
  logic [7:0]  fifo_ctrl_q;
  logic [7:0]  line_ctrl_q;
  logic [7:0]  modem_control_reg;
  logic [7:0]  alternate_function_reg;
  logic [15:0] divisor_q;
  logic        ring_prev_q;
  logic        ring_delta_q;
  fifo_state_s txf_q;
  fifo_state_s rxf_q;
  logic [7:0]  tx_head;
  logic [7:0]  rx_head;
  logic [15:0] div_cnt_q;
  logic        tick;
  logic        baud_clk_q;
  tx_state_e   tx_state_q;
  logic [3:0]  tx_tick_q;
  logic [2:0]  tx_bit_q;
  logic [7:0]  tx_shift_q;
  logic        tx_line_q;
  rx_state_e   rx_state_q;
  logic [3:0]  rx_tick_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_shift_q;
  logic        rx_push;
  logic        rx_in;
  logic        wr_en;
  logic        rd_en;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_pop;
  logic        hit;
  logic        loop;
  logic [15:0] div_eff;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign loop  = line_ctrl_q[`LC_LOOP_BIT];
  assign div_eff = (divisor_q == 16'h0000) ? `RST_DIVISOR : divisor_q;

  // Zero wait states: the data register is valid from the setup cycle
  assign pready = 1'b1;

  always_comb
  begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `OFS_DATA:       prdata = {24'h00_0000, rx_head};
      `OFS_INT_EN:     prdata = {24'h00_0000, int_en_q};
      `OFS_FIFO_CTRL:  prdata = {24'h00_0000, fifo_ctrl_q};
      `OFS_LINE_CTRL:  prdata = {24'h00_0000, line_ctrl_q};
      `OFS_MODEM_CTRL: prdata = {24'h00_0000, modem_control_reg};
      `OFS_STATUS:     prdata = {19'h0_0000, txf_q.count, 3'h0, rxf_q.count};
      `OFS_MODEM_STAT: prdata = {30'h0000_0000, ring_indicator_n_a, ring_delta_q};
      `OFS_DIVISOR:    prdata = {16'h0000, divisor_q};
      `OFS_ALT_FUNC:   prdata = {24'h00_0000, alternate_function_reg};
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  assign pslverr = psel && penable && !hit;

  assign tx_push = wr_en && (paddr == `OFS_DATA) && (txf_q.count != `FIFO_FULL);
  assign rx_pop  = rd_en && (paddr == `OFS_DATA) && (rxf_q.count != 5'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_en_q               <= 8'h00;
      fifo_ctrl_q            <= 8'h00;
      line_ctrl_q            <= `RST_LINE_CTRL;
      modem_control_reg      <= 8'h00;
      alternate_function_reg <= 8'h00;
      divisor_q              <= `RST_DIVISOR;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_INT_EN:     int_en_q               <= pwdata[7:0];
        `OFS_FIFO_CTRL:  fifo_ctrl_q            <= pwdata[7:0];
        `OFS_LINE_CTRL:  line_ctrl_q            <= pwdata[7:0];
        `OFS_MODEM_CTRL: modem_control_reg      <= pwdata[7:0];
        `OFS_DIVISOR:    divisor_q              <= pwdata[15:0];
        `OFS_ALT_FUNC:   alternate_function_reg <= pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // Ring edge flag; a new edge beats the clearing read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ring_prev_q  <= 1'b1;
      ring_delta_q <= 1'b0;
    end
    else
    begin
      ring_prev_q <= ring_indicator_n_a;
      if (!ring_prev_q && ring_indicator_n_a)
      begin
        ring_delta_q <= 1'b1;
      end
      else if (rd_en && (paddr == `OFS_MODEM_STAT))
      begin
        ring_delta_q <= 1'b0;
      end
    end
  end

  assign modem_irq = ring_delta_q && int_en_q[`IE_MODEM_BIT];

  // Sixteen-times tick and its visible clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q  <= 16'h0000;
      baud_clk_q <= 1'b0;
    end
    else
    begin
      div_cnt_q  <= tick ? 16'h0000 : div_cnt_q + 16'h0001;
      baud_clk_q <= (div_cnt_q < (div_eff >> 1));
    end
  end

  assign tick = (div_cnt_q >= div_eff - 16'h0001);

  byte_store u_tx_store
  (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (tx_push),
    .waddr   (txf_q.wr_ptr),
    .wdata   (pwdata[7:0]),
    .raddr   (txf_q.rd_ptr),
    .rdata_q (tx_head)
  );

  byte_store u_rx_store
  (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (rx_push),
    .waddr   (rxf_q.wr_ptr),
    .wdata   (rx_shift_q),
    .raddr   (rxf_q.rd_ptr),
    .rdata_q (rx_head)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txf_q <= '0;
      rxf_q <= '0;
    end
    else
    begin
      txf_q <= fifo_next(txf_q, tx_push, tx_pop);
      rxf_q <= fifo_next(rxf_q, rx_push, rx_pop);
    end
  end

  // LOAD waits one edge for the registered head byte
  assign tx_pop = (tx_state_q == TX_LOAD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_q <= TX_IDLE;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_line_q  <= 1'b1;
    end
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          tx_line_q <= 1'b1;
          if (line_ctrl_q[`LC_TXEN_BIT] && (txf_q.count != 5'h00))
          begin
            tx_state_q <= TX_LOAD;
          end
        end
        TX_LOAD:
        begin
          tx_shift_q <= tx_head;
          tx_tick_q  <= 4'h0;
          tx_state_q <= TX_START;
        end
        TX_START:
        begin
          if (tick)
          begin
            tx_line_q <= 1'b0;
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == `TICKS_PER_BIT)
            begin
              tx_bit_q   <= 3'h0;
              tx_line_q  <= tx_shift_q[0];
              tx_state_q <= TX_DATA;
            end
          end
        end
        TX_DATA:
        begin
          if (tick)
          begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == `TICKS_PER_BIT)
            begin
              tx_shift_q <= {1'b1, tx_shift_q[7:1]};
              tx_line_q  <= tx_shift_q[1];
              tx_bit_q   <= tx_bit_q + 3'h1;
              if (tx_bit_q == `DATA_BITS)
              begin
                tx_line_q  <= 1'b1;
                tx_state_q <= TX_STOP;
              end
            end
          end
        end
        TX_STOP:
        begin
          if (tick)
          begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == `TICKS_PER_BIT)
            begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default:
        begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Receiver sees own transmit line in loopback
  assign rx_in = loop ? tx_line_q : serial_in_a;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q <= RX_IDLE;
      rx_tick_q  <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_push    <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      case (rx_state_q)
        RX_IDLE:
        begin
          rx_tick_q <= 4'h0;
          if (!rx_in)
          begin
            rx_state_q <= RX_START;
          end
        end
        RX_START:
        begin
          if (tick)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == `TICK_MID)
            begin
              // Glitch shorter than half a bit is not a start
              rx_tick_q  <= 4'h0;
              rx_bit_q   <= 3'h0;
              rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA:
        begin
          if (tick)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == `TICKS_PER_BIT)
            begin
              rx_shift_q <= {rx_in, rx_shift_q[7:1]};
              rx_bit_q   <= rx_bit_q + 3'h1;
              if (rx_bit_q == `DATA_BITS)
              begin
                rx_state_q <= RX_STOP;
              end
            end
          end
        end
        RX_STOP:
        begin
          if (tick)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == `TICKS_PER_BIT)
            begin
              // Overrun drops the new byte; bad stop bit also drops it
              rx_push    <= rx_in && (rxf_q.count != `FIFO_FULL);
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default:
        begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Mode 1 waits for the trigger level, mode 0 for one byte
  always_comb
  begin
    if (fifo_ctrl_q[`FC_DMA_BIT])
    begin
      receive_ready_n = (rxf_q.count <
        trig_level(fifo_ctrl_q[`FC_TRIG_HI:`FC_TRIG_LO]));
    end
    else
    begin
      receive_ready_n = (rxf_q.count == 5'h00);
    end
  end

  assign transmit_ready_n_a = (txf_q.count == `FIFO_FULL);

  // Serial, multi-function, RTS and terminal-ready pins from flops; all four idle high in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_out_a         <= 1'b1;
      multi_function_out_a <= 1'b1;
      request_to_send_n_a  <= 1'b1;
      terminal_ready_n_a   <= 1'b1;
    end
    else
    begin
      serial_out_a        <= loop ? 1'b1 : tx_line_q;
      request_to_send_n_a <= !modem_control_reg[`MC_RTS_BIT];
      terminal_ready_n_a  <= !modem_control_reg[`MC_TERM_BIT];
      case (mf_sel_e'(alternate_function_reg[`AF_SEL_HI:`AF_SEL_LO]))
        MF_BAUD: multi_function_out_a <= baud_clk_q;
        MF_RXRD: multi_function_out_a <= receive_ready_n;
        default: multi_function_out_a <= !modem_control_reg[`MC_OUT2_BIT];
      endcase
    end
  end

endmodule

// ===== src/uart_chan_map.svh
`ifndef UART_CHAN_MAP_SVH
`define UART_CHAN_MAP_SVH

// Register byte offsets
`define OFS_DATA        8'h00
`define OFS_INT_EN      8'h04
`define OFS_FIFO_CTRL   8'h08
`define OFS_LINE_CTRL   8'h0C
`define OFS_MODEM_CTRL  8'h10
`define OFS_STATUS      8'h14
`define OFS_MODEM_STAT  8'h18
`define OFS_DIVISOR     8'h1C
`define OFS_ALT_FUNC    8'h20

// Field positions
`define IE_MODEM_BIT    0
`define FC_DMA_BIT      0
`define FC_TRIG_HI      7
`define FC_TRIG_LO      6
`define LC_TXEN_BIT     0
`define LC_LOOP_BIT     1
`define MC_TERM_BIT     0
`define MC_RTS_BIT      1
`define MC_OUT2_BIT     3
`define AF_SEL_HI       2
`define AF_SEL_LO       1
`define MS_DELTA_BIT    0
`define MS_RING_BIT     1

// Reset values
`define RST_DIVISOR     16'h0001
`define RST_LINE_CTRL   8'h01

// Structure
`define FIFO_DEPTH      16
`define FIFO_FULL       5'h10
`define PTR_W           4
`define CNT_W           5
`define TICKS_PER_BIT   4'hF
`define TICK_MID        4'h7
`define DATA_BITS       3'h7

// Receive trigger levels
`define TRIG_0          5'h01
`define TRIG_1          5'h04
`define TRIG_2          5'h08
`define TRIG_3          5'h0E

`endif

// ===== src/uart_chan_pkg.sv
package uart_chan_pkg;

  typedef struct packed {
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [4:0] count;
  } fifo_state_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_LOAD  = 3'b001,
    TX_START = 3'b010,
    TX_DATA  = 3'b011,
    TX_STOP  = 3'b100
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;

  typedef enum logic [1:0] {
    MF_OUT2 = 2'b00,
    MF_BAUD = 2'b01,
    MF_RXRD = 2'b10,
    MF_ALT  = 2'b11
  } mf_sel_e;

endpackage

// ===== src/byte_store.sv
`timescale 1ns/1ps
`include "uart_chan_map.svh"

module byte_store
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                we,
  input  wire logic [`PTR_W-1:0]   waddr,
  input  wire logic [7:0]          wdata,
  input  wire logic [`PTR_W-1:0]   raddr,
  output logic      [7:0]          rdata_q
);

  logic [7:0] mem [`FIFO_DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read data lags the address by one edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// ===== test/uart_chan_asserts.sv
`timescale 1ns/1ps
module uart_chan_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        serial_out_a,
  input wire logic        multi_function_out_a,
  input wire logic        receive_ready_n,
  input wire logic        transmit_ready_n_a,
  input wire logic        request_to_send_n_a,
  input wire logic        terminal_ready_n_a,
  input wire logic        ring_indicator_n_a,
  input wire logic        modem_irq
);
  logic       wr;
  logic [1:0] sel_q;
  logic       mc3_q;
  logic       loop_q;
  logic       ie_q;
  assign wr = psel && penable && pwrite;
  // Shadow copies of the few control bits the properties depend on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q  <= 2'h0;
      mc3_q  <= 1'b0;
      loop_q <= 1'b0;
      ie_q   <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == 8'h20) sel_q <= pwdata[2:1];
      if (paddr == 8'h10) mc3_q <= pwdata[3];
      if (paddr == 8'h0C) loop_q <= pwdata[1];
      if (paddr == 8'h04) ie_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rts_follow_a: assert property (wr && paddr == 8'h10 |=>
    ##1 request_to_send_n_a == !$past(pwdata[1], 2)) else $error("rts level wrong");
  dtr_follow_a: assert property (wr && paddr == 8'h10 |=>
    ##1 terminal_ready_n_a == !$past(pwdata[0], 2)) else $error("dtr level wrong");
  reset_outputs_a: assert property ($rose(presetn) |-> serial_out_a &&
    multi_function_out_a && request_to_send_n_a && terminal_ready_n_a && receive_ready_n
    && !transmit_ready_n_a && !modem_irq) else $error("reset outputs wrong");
  loop_quiet_a: assert property (loop_q && $past(loop_q) |-> serial_out_a)
    else $error("tx pin active in loopback");
  mf_out2_a: assert property ((sel_q == 2'h0 || sel_q == 2'h3) && $stable(sel_q)
    && $stable(mc3_q) |-> multi_function_out_a == !mc3_q) else $error("mf out2 wrong");
  mf_rxready_a: assert property (sel_q == 2'h2 && $stable(sel_q)
    |-> multi_function_out_a == $past(receive_ready_n)) else $error("mf rxready wrong");
  ring_irq_a: assert property ($rose(ring_indicator_n_a) && ie_q |-> ##[1:3] modem_irq)
    else $error("ring irq missing");
  irq_masked_a: assert property (!ie_q |-> !modem_irq)
    else $error("irq while masked");
endmodule

// ===== test/serial_device.sv
`timescale 1ns/1ps
module serial_device
(
  input  wire logic pclk,
  output logic      line,
  output logic      ring_n
);
  initial
  begin
    line   = 1'b1;
    ring_n = 1'b1;
  end
  // One 8N1 frame at sixteen cycles a bit, line left idle high after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
      repeat (16) @(posedge pclk) line <= f[i];
  endtask
  task automatic ring;
    @(posedge pclk) ring_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ring_n <= 1'b1;
  endtask
endmodule

// ===== test/tb_uart_channel_pin_functions.sv
`timescale 1ns/1ps
module tb_uart_channel_pin_functions;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sin, ring_n, sout, mf, rxr_n, txr_n, rts_n, dtr_n, irq;
  int          num_errors = 0;
  int          check_count = 0;
  uart_chan dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_a(sin), .ring_indicator_n_a(ring_n), .serial_out_a(sout),
    .multi_function_out_a(mf), .receive_ready_n(rxr_n), .transmit_ready_n_a(txr_n),
    .request_to_send_n_a(rts_n), .terminal_ready_n_a(dtr_n), .modem_irq(irq));
  serial_device dev (.pclk(pclk), .line(sin), .ring_n(ring_n));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #2000000;
    num_errors++;
    end_of_test;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp1(input logic g, input logic x);
    check_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t bit got %b exp %b", $time, g, x);
    end
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, g, x);
    end
  endtask
  // Request held until pready is seen high; answer taken at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdw(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp32(rd, x);
  endtask
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial
  begin
    logic [7:0] b;
    logic [7:0] v [4];
    logic [9:0] f;
    logic       last;
    int         k, n, d;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    void'($urandom(68359));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp1(sout, 1'b1);
    cmp1(rts_n, 1'b1);
    cmp1(mf, 1'b1);
    cmp32({28'h0, dtr_n, rxr_n, txr_n, irq}, 32'h0000000C);
    rdw(8'h0C, 32'h00000001);
    rdw(8'h1C, 32'h00000001);
    apb(1'b0, 8'h30, 32'h0);
    cmp1(er, 1'b1);
    done("reset");
    for (k = 0; k < 6; k++)
    begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'h0B : 8'($urandom);
      wr(8'h10, {24'h0, b});
      settle;
      cmp1(rts_n, ~b[1]);
      cmp1(dtr_n, ~b[0]);
      cmp1(mf, ~b[3]);
    end
    done("modem control");
    wr(8'h10, 32'h8);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h20, 32'(k << 1));
      settle;
      cmp1(mf, k == 2);
    end
    wr(8'h10, 32'h0);
    settle;
    cmp1(mf, 1'b1);
    d = $urandom_range(6, 2);
    wr(8'h1C, 32'(d));
    wr(8'h20, 32'h2);
    settle;
    n = 0;
    last = mf;
    repeat (20 * d)
    begin
      @(negedge pclk);
      n += (mf && !last);
      last = mf;
    end
    cmp32(32'(n), 32'h14);
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h4);
    done("select");
    b = 8'($urandom);
    dev.send(b);
    repeat (4) @(negedge pclk);
    cmp1(rxr_n, 1'b0);
    cmp1(mf, 1'b0);
    rdw(8'h00, {24'h0, b});
    @(negedge pclk);
    cmp1(rxr_n, 1'b1);
    wr(8'h08, 32'h41);
    for (k = 0; k < 4; k++)
    begin
      v[k] = 8'($urandom);
      dev.send(v[k]);
      repeat (4) @(negedge pclk);
      cmp1(rxr_n, k != 3);
    end
    for (k = 0; k < 4; k++)
      rdw(8'h00, {24'h0, v[k]});
    wr(8'h08, 32'h0);
    done("receive ready");
    wr(8'h0C, 32'h3);
    b = 8'($urandom);
    n = 0;
    fork
      dev.send(~b);
      wr(8'h00, {24'h0, b});
      repeat (220)
      begin
        @(negedge pclk);
        n += !sout;
      end
    join
    cmp32(32'(n), 32'h0);
    rdw(8'h14, 32'h00000001);
    rdw(8'h00, {24'h0, b});
    wr(8'h0C, 32'h1);
    done("loopback");
    b = 8'($urandom);
    wr(8'h00, {24'h0, b});
    n = 0;
    while (sout !== 1'b0 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    repeat (8) @(negedge pclk);
    for (k = 0; k < 10; k++)
    begin
      f[k] = sout;
      repeat (16) @(negedge pclk);
    end
    cmp32({22'h0, f}, {22'h0, 1'b1, b, 1'b0});
    cmp1(sout, 1'b1);
    done("transmit");
    wr(8'h04, 32'h1);
    dev.ring();
    repeat (3) @(negedge pclk);
    cmp1(irq, 1'b1);
    rdw(8'h18, 32'h00000003);
    settle;
    cmp1(irq, 1'b0);
    wr(8'h04, 32'h0);
    dev.ring();
    repeat (3) @(negedge pclk);
    cmp1(irq, 1'b0);
    rdw(8'h18, 32'h00000003);
    done("ring");
    wr(8'h0C, 32'h0);
    for (k = 0; k < 17; k++)
    begin
      wr(8'h00, 32'($urandom_range(255, 0)));
      @(negedge pclk);
      cmp1(txr_n, k >= 15);
    end
    cmp1(sout, 1'b1);
    rdw(8'h14, 32'h00001000);
    wr(8'h0C, 32'h1);
    repeat (30) @(negedge pclk);
    cmp1(txr_n, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    cmp1(sout, 1'b1);
    cmp1(txr_n, 1'b0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    rdw(8'h14, 32'h0);
    done("full store and reset");
    end_of_test;
  end
endmodule
bind uart_chan uart_chan_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .serial_out_a(serial_out_a), .multi_function_out_a(multi_function_out_a),
  .receive_ready_n(receive_ready_n), .transmit_ready_n_a(transmit_ready_n_a),
  .request_to_send_n_a(request_to_send_n_a), .terminal_ready_n_a(terminal_ready_n_a),
  .ring_indicator_n_a(ring_indicator_n_a), .modem_irq(modem_irq));
